//--- rtl/prog_data_map.svh
// Offsets, widths, reset vectors and variant codes for the address map block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef PROG_DATA_MAP_SVH
`define PROG_DATA_MAP_SVH

`define VARIANT_SMALL      2'h0
`define VARIANT_MID        2'h1
`define VARIANT_LARGE      2'h2
`define PC_WIDTH_SMALL     9
`define PC_WIDTH_LARGE     11
`define PC_MAX_WIDTH       11
`define INSTR_WIDTH        12
`define RESET_VEC_SMALL    11'h1FF
`define RESET_VEC_LARGE    11'h7FF
`define PC_ZERO            11'h000
`define PAGE_MASK_MID      2'h1
`define PAGE_MASK_LARGE    2'h3
`define SFR_COUNT_SMALL    5'h07
`define SFR_COUNT_MID      5'h08
`define SFR_COUNT_LARGE    5'h0A
`define GPR_COUNT_SMALL    5'h19
`define GPR_UNBANKED_MID   5'h08
`define GPR_UNBANKED_LARGE 5'h06
`define GPR_BANKED_MID     8'h40
`define GPR_BANKED_LARGE   8'h80
`define FILE_ADDR_WIDTH    5
`define BANK_BITS_MID      3'h3
`define BANK_BITS_LARGE    3'h7
`define BANK_SHARED_LIMIT  5'h10
`define INDIRECT_ADDR      5'h00
`define DATA_ADDR_WIDTH    8
`define QUARTER_DIV_LAST   2'h3
`define OSC_MODE_RC        2'h3

`endif

//--- rtl/prog_data_pkg.sv
// Types shared by the address map block.
// Assumes the constants header sits next to it.
package prog_data_pkg;
	`include "prog_data_map.svh"

	typedef enum logic [2:0] {
		ST_RESET  = 3'h1,
		ST_RUN    = 3'h2,
		ST_BRANCH = 3'h4
	} seq_state_t;

	typedef struct packed {
		logic        is_branch;
		logic [10:0] target;
		logic [7:0]  direct_addr;
	} fetch_ctl_t;

	typedef struct packed {
		seq_state_t  state;
		logic [10:0] pc;
		logic [1:0]  quarter_cnt;
		logic        quarter_clk;
		logic        fetch_valid;
		logic [10:0] fetch_addr;
		logic [7:0]  data_addr;
		logic        data_banked;
	} core_state_t;
endpackage

//--- rtl/prog_data_map_top.sv
// Program counter, reset vector, paging, data banking and clock-out divider.
// Assumes the instruction word and decode hints come from the fetch path each cycle.
`timescale 1ns/1ns
`include "prog_data_map.svh"

// Notes on behaviour
// - Small variant: 9-bit counter over 512 twelve-bit words.
// - Larger variants: 11-bit counter over 2K twelve-bit words.
// - Fetches past implemented memory wrap into it.
// - Reset starts at last word, 1FFh or 7FFh.
// - No-op at reset vector rolls counter over to 000h.
// - Larger variants page program memory with one or two status bits.
// - Register files over 32 entries bank through the file select pointer.
// - Small variant: 7 special, 25 general registers, unbanked.
// - Mid variant: 8 special, 8 shared, 64 banked general registers.
// - Large variant: 10 special, 6 shared, 128 banked general registers.
// - Register file reached directly or through the file select pointer.
// - RC mode drives clock-out at a quarter of the oscillator rate.
// - Fetch sequencer held in reset while master reset input is low; data map and clock-out keep running.
// - One cycle per instruction, branches take two.
// - Each instruction is one 12-bit word at one location.
module prog_data_map_top
	import prog_data_pkg::*;
(
	input  wire logic                     clk_sys,
	input  wire logic                     rst_n,
	input  wire logic                     master_reset_in_n,
	input  wire logic [1:0]               variant,
	input  wire logic [1:0]               osc_mode,
	input  wire logic [`INSTR_WIDTH-1:0]  instr_word,
	input  wire fetch_ctl_t               fetch_ctl,
	input  wire logic [1:0]               status_page,
	input  wire logic [7:0]               file_select_pointer,
	output logic [10:0]                   fetch_addr,
	output logic                          fetch_valid,
	output logic [7:0]                    data_addr,
	output logic                          data_banked,
	output logic                          quarter_clock_out
);

	// ----------------------------------------
	// Variant decoding
	// ----------------------------------------
	function automatic logic [10:0] pc_mask(input logic [1:0] v);
		pc_mask = (v == `VARIANT_SMALL) ? `RESET_VEC_SMALL : `RESET_VEC_LARGE;
	endfunction

	function automatic logic [10:0] reset_vec(input logic [1:0] v);
		reset_vec = (v == `VARIANT_SMALL) ? `RESET_VEC_SMALL : `RESET_VEC_LARGE;
	endfunction

	function automatic logic [1:0] page_mask(input logic [1:0] v);
		case (v)
			`VARIANT_MID:   page_mask = `PAGE_MASK_MID;
			`VARIANT_LARGE: page_mask = `PAGE_MASK_LARGE;
			default:        page_mask = 2'h0;
		endcase
	endfunction

	// Banked data address: low nibble in a shared window stays shared, otherwise
	// pointer bits 7:5 choose the bank, only 6:5 on the mid variant; small variant ignores them.
	function automatic logic [7:0] map_data(input logic [1:0] v, input logic [7:0] a);
		logic [2:0] bank;
		bank = 3'h0;
		case (v)
			`VARIANT_MID:   bank = a[7:5] & `BANK_BITS_MID;
			`VARIANT_LARGE: bank = a[7:5] & `BANK_BITS_LARGE;
			default:        bank = 3'h0;
		endcase
		if (a[4:0] < `BANK_SHARED_LIMIT)
			map_data = {3'h0, a[4:0]};
		else
			map_data = {bank, a[4:0]};
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	core_state_t s_reg;
	core_state_t s_next;
	logic        run_ok;
	logic [7:0]  raw_addr;

	assign run_ok = master_reset_in_n;

	always_comb begin
		s_next = s_reg;
		// Indirect slot selects the pointer; a direct operand keeps the pointer's bank
		// bits, so both access kinds reach the same bank of the banked window
		raw_addr = (fetch_ctl.direct_addr[4:0] == `INDIRECT_ADDR) ?
			file_select_pointer : {file_select_pointer[7:5], fetch_ctl.direct_addr[4:0]};
		s_next.data_addr   = map_data(variant, raw_addr);
		s_next.data_banked = (s_next.data_addr[7:5] != 3'h0);
		if (osc_mode == `OSC_MODE_RC) begin
			s_next.quarter_cnt = s_reg.quarter_cnt + 2'h1;
			if (s_reg.quarter_cnt[0])
				s_next.quarter_clk = ~s_reg.quarter_clk;
		end else begin
			s_next.quarter_cnt = 2'h0;
			s_next.quarter_clk = 1'b0;
		end
		if (!run_ok) begin
			s_next.state       = ST_RESET;
			s_next.pc          = reset_vec(variant);
			s_next.fetch_valid = 1'b0;
			s_next.fetch_addr  = reset_vec(variant);
		end else begin
			case (s_reg.state)
				ST_RESET: begin
					s_next.state       = ST_RUN;
					// Trim the counter too, so a small part really sits at its own top word
					s_next.pc          = s_reg.pc & pc_mask(variant);
					s_next.fetch_addr  = s_reg.pc & pc_mask(variant);
					s_next.fetch_valid = 1'b1;
				end
				ST_RUN: begin
					if (fetch_ctl.is_branch) begin
						// Branch spends a second cycle flushing the prefetched word
						s_next.state       = ST_BRANCH;
						s_next.pc          = ({page_mask(variant), 9'h000} & {status_page, 9'h000}) |
							({2'h0, fetch_ctl.target[8:0]});
						s_next.fetch_valid = 1'b0;
					end else begin
						// Counter rolls over at the top, so a no-op at the vector lands on 000h
						s_next.pc          = (s_reg.pc + 11'h001) & pc_mask(variant);
						s_next.fetch_addr  = (s_reg.pc + 11'h001) & pc_mask(variant);
						s_next.fetch_valid = 1'b1;
					end
				end
				ST_BRANCH: begin
					s_next.state       = ST_RUN;
					s_next.pc          = s_reg.pc & pc_mask(variant);
					s_next.fetch_addr  = s_reg.pc & pc_mask(variant);
					s_next.fetch_valid = 1'b1;
				end
				default: begin
					s_next.state = ST_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_reg.state       <= ST_RESET;
			s_reg.pc          <= `RESET_VEC_LARGE;
			s_reg.quarter_cnt <= 2'h0;
			s_reg.quarter_clk <= 1'b0;
			s_reg.fetch_valid <= 1'b0;
			s_reg.fetch_addr  <= `RESET_VEC_LARGE;
			s_reg.data_addr   <= 8'h00;
			s_reg.data_banked <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign fetch_addr        = s_reg.fetch_addr;
	assign fetch_valid       = s_reg.fetch_valid;
	assign data_addr         = s_reg.data_addr;
	assign data_banked       = s_reg.data_banked;
	assign quarter_clock_out = s_reg.quarter_clk;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic unused_instr;
	assign unused_instr = ^instr_word;

	chk_small_width: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(variant == `VARIANT_SMALL) |-> fetch_addr[10:9] == 2'h0 || !fetch_valid)
		else $error("small variant fetch above 9 bits");
	chk_reset_vector: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!master_reset_in_n ##1 master_reset_in_n) |=> fetch_addr == reset_vec($past(variant)))
		else $error("first fetch not at reset vector");
	chk_hold_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!master_reset_in_n |=> !fetch_valid)
		else $error("fetch while held in reset");
	chk_wrap_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(master_reset_in_n && s_reg.state == ST_RUN && !fetch_ctl.is_branch &&
		s_reg.pc == pc_mask(variant)) |=> fetch_addr == `PC_ZERO)
		else $error("no rollover to zero");
	chk_branch_two: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(master_reset_in_n && s_reg.state == ST_RUN && fetch_ctl.is_branch) |=> !fetch_valid)
		else $error("branch not two cycles");
	chk_step_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(master_reset_in_n && s_reg.state == ST_RUN && !fetch_ctl.is_branch) |=> fetch_valid)
		else $error("plain instruction stalled");
	chk_quarter_clk: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(osc_mode == `OSC_MODE_RC && $rose(quarter_clock_out)) ##1 (osc_mode == `OSC_MODE_RC) [*3]
		|=> $rose(quarter_clock_out) && !$past(quarter_clock_out, 2) && $past(quarter_clock_out, 3))
		else $error("clock-out not a quarter rate");
	chk_small_unbanked: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(variant == `VARIANT_SMALL) |=> !data_banked || $past(variant) != `VARIANT_SMALL)
		else $error("small variant banked");
	chk_branch_page: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(master_reset_in_n && s_reg.state == ST_RUN && fetch_ctl.is_branch) ##1 master_reset_in_n
		|=> fetch_addr == {$past(status_page, 2) & page_mask($past(variant, 2)), $past(fetch_ctl.target[8:0], 2)})
		else $error("branch target page not applied");
	chk_shared_window: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(data_addr[4:0] < `BANK_SHARED_LIMIT) |-> data_addr[7:5] == 3'h0)
		else $error("shared register banked");
	chk_mid_bank: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(variant == `VARIANT_MID) |=> !data_addr[7])
		else $error("mid variant bank out of range");
	chk_large_bank: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(variant == `VARIANT_LARGE && fetch_ctl.direct_addr[4:0] >= `BANK_SHARED_LIMIT)
		|=> data_addr[7:5] == $past(file_select_pointer[7:5]))
		else $error("bank not taken from pointer");
	chk_indirect_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(fetch_ctl.direct_addr[4:0] == `INDIRECT_ADDR) |=> data_addr[4:0] == $past(file_select_pointer[4:0]))
		else $error("indirect address not from pointer");
	chk_direct_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(fetch_ctl.direct_addr[4:0] != `INDIRECT_ADDR) |=> data_addr[4:0] == $past(fetch_ctl.direct_addr[4:0]))
		else $error("direct address not from instruction");
	chk_quarter_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(osc_mode != `OSC_MODE_RC) |=> !quarter_clock_out)
		else $error("clock-out running outside RC mode");

	// ----------------------------------------
	// Coverage
	// ----------------------------------------
	cov_branch: cover property (@(posedge clk_sys) disable iff (!rst_n) s_reg.state == ST_BRANCH);
	cov_wrap: cover property (@(posedge clk_sys) disable iff (!rst_n) fetch_valid && fetch_addr == `PC_ZERO);
	cov_banked: cover property (@(posedge clk_sys) disable iff (!rst_n) data_banked);
	cov_quarter: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(quarter_clock_out));
	cov_small_vector: cover property (@(posedge clk_sys) disable iff (!rst_n)
		fetch_valid && fetch_addr == `RESET_VEC_SMALL);
endmodule

//--- verif/prog_data_map_top_bench.sv
// Self-checking bench for the program and data address map block.
// Assumes the package and constants header are compiled first.
`timescale 1ns/1ns
`include "prog_data_map.svh"
module prog_data_map_top_bench;
	import prog_data_pkg::*;
	logic                    clk_sys = 1'b0;
	logic                    rst_n = 1'b0;
	logic                    master_reset_in_n = 1'b1;
	logic [1:0]              variant = 2'h0;
	logic [1:0]              osc_mode = 2'h0;
	logic [`INSTR_WIDTH-1:0] instr_word = 12'hA5C;
	fetch_ctl_t              fctl = '0;
	logic [1:0]              status_page = 2'h0;
	logic [7:0]              file_select_pointer = 8'h00;
	logic [10:0]             fetch_addr;
	logic                    fetch_valid;
	logic [7:0]              data_addr;
	logic                    data_banked;
	logic                    quarter_clock_out;
	int                      failures = 0;
	int                      samples_checked = 0;

	always #5 clk_sys = ~clk_sys;

	prog_data_map_top u_prog_data_map_top (.clk_sys(clk_sys), .rst_n(rst_n),
		.master_reset_in_n(master_reset_in_n), .variant(variant), .osc_mode(osc_mode),
		.instr_word(instr_word), .fetch_ctl(fctl), .status_page(status_page),
		.file_select_pointer(file_select_pointer), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
		.data_addr(data_addr), .data_banked(data_banked), .quarter_clock_out(quarter_clock_out));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Sampling at the falling edge keeps reads clear of the launching edge
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic results();
		if (failures == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic reset_start(input logic [1:0] v);
		logic [10:0] vec;
		vec = (v == `VARIANT_SMALL) ? `RESET_VEC_SMALL : `RESET_VEC_LARGE;
		rst_n = 1'b0;
		variant = v;
		tick(4);
		chk({fetch_valid, fetch_addr}, {1'b0, 11'h7FF});
		rst_n = 1'b1;
		tick(1);
		chk({fetch_valid, fetch_addr}, {1'b1, vec});
		tick(1);
		chk({fetch_valid, fetch_addr}, {1'b1, 11'h000});
		tick(1);
		chk({fetch_valid, fetch_addr}, {1'b1, 11'h001});
	endtask

	task automatic master_reset(input logic [1:0] v);
		logic [10:0] vec;
		vec = (v == `VARIANT_SMALL) ? `RESET_VEC_SMALL : `RESET_VEC_LARGE;
		master_reset_in_n = 1'b0;
		tick(2);
		chk({fetch_valid, fetch_addr}, {1'b0, vec});
		master_reset_in_n = 1'b1;
		tick(1);
		chk({fetch_valid, fetch_addr}, {1'b1, vec});
		tick(1);
		chk({fetch_valid, fetch_addr}, {1'b1, 11'h000});
	endtask

	task automatic branch(input logic [1:0] v, input logic [1:0] page);
		logic [1:0] pm;
		pm = (v == `VARIANT_SMALL) ? 2'h0 : ((v == `VARIANT_MID) ? 2'h1 : 2'h3);
		fctl.is_branch = 1'b1;
		fctl.target = 11'h5A5;
		status_page = page;
		tick(1);
		chk({fetch_valid, 11'h000}, 12'h000);
		fctl.is_branch = 1'b0;
		tick(1);
		chk({fetch_valid, fetch_addr}, {1'b1, page & pm, 9'h1A5});
		tick(1);
		chk({fetch_valid, fetch_addr}, {1'b1, page & pm, 9'h1A6});
	endtask

	task automatic data_map(input logic [1:0] v);
		logic [7:0] da [4] = '{8'h05, 8'h15, 8'h00, 8'h00};
		logic [7:0] fp [4] = '{8'hE0, 8'hA0, 8'h7C, 8'hE8};
		logic [4:0] a5;
		logic [2:0] bk;
		for (int i = 0; i < 4; i++) begin
			fctl.direct_addr = da[i];
			file_select_pointer = fp[i];
			a5 = (da[i][4:0] == 5'h00) ? fp[i][4:0] : da[i][4:0];
			bk = (v == `VARIANT_SMALL || a5 < 5'h10) ? 3'h0 : fp[i][7:5] & ((v == `VARIANT_MID) ? 3'h3 : 3'h7);
			tick(1);
			chk({data_banked, 3'h0, data_addr}, {bk != 3'h0, 3'h0, bk, a5});
		end
	endtask

	task automatic quarter_clock();
		logic       prev;
		logic [3:0] n;
		n = 4'h0;
		osc_mode = `OSC_MODE_RC;
		tick(2);
		prev = quarter_clock_out;
		repeat (8) begin
			tick(1);
			if (quarter_clock_out !== prev) n++;
			prev = quarter_clock_out;
		end
		chk({8'h00, n}, 12'h004);
		osc_mode = 2'h0;
		tick(2);
		repeat (4) begin
			tick(1);
			chk({11'h000, quarter_clock_out}, 12'h000);
		end
	endtask

	// Generous span: the whole sequence needs well under a thousand cycles
	initial begin
		#100000;
		failures++;
		results();
	end

	initial begin
		for (int v = 0; v < 3; v++) begin
			reset_start(v[1:0]);
			branch(v[1:0], 2'h3);
			data_map(v[1:0]);
			master_reset(v[1:0]);
		end
		quarter_clock();
		results();
	end
endmodule
